// ### logic/irqepb_bank.sv
// Purpose: enable and priority bank of the interrupt controller, apb slave
// Assumes: src_pulse, ext_en, ext_prio synchronous to clk
// Notes:   sources 0..10 own a priority field here and take their enable
//          from ext_en; sources 11..16 own an enable here and take their
//          priority from ext_prio
// How it works
// - enable word 3 bit 15 gates the pwm fault a request.
// - enable word 3 bit 14 gates the calendar clock request.
// - enable word 3 bit 9 gates the motor pwm request.
// - enable word 4 bit 13 gates the charge time unit request.
// - enable word 4 bit 1 gates the serial error request.
// - enable word 4 bit 0 gates the pwm fault b request.
// - an enable of one lets a request through, zero blocks it, all reset to zero.
// - a priority field is a binary level, seven highest and one lowest.
// - a priority field of zero disables its source whatever its enable says.
// - every priority field resets to level four.
// - unimplemented bits read zero and ignore writes.
// - priority word 0 holds timer one, compare one, capture one, ext irq zero.
// - priority word 1 holds timer two, compare two, capture two, bits 3-0 empty.
// - priority word 2 holds serial receive, spi event, spi error, timer three.
// - each source has a flag that reads one once its request occurred.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "irqepb_map.svh"
module irqepb_bank
   import irqepb_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [16:0]         src_pulse,
   input  wire logic [10:0]         ext_en,
   input  wire logic [17:0]         ext_prio,
   output logic                     irq_req,
   output logic [2:0]               irq_level,
   output logic [4:0]               irq_src
);
   // ----------------------------------------------------------------
   // source tables
   // ----------------------------------------------------------------
   localparam int NS = `IRQEPB_NSRC;
   localparam int NP = `IRQEPB_NPRI;
   localparam int P_REG [NP] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
   localparam int P_LSB [NP] = '{`IRQEPB_FLD_3, `IRQEPB_FLD_2, `IRQEPB_FLD_1,
                                 `IRQEPB_FLD_0, `IRQEPB_FLD_3, `IRQEPB_FLD_2,
                                 `IRQEPB_FLD_1, `IRQEPB_FLD_3, `IRQEPB_FLD_2,
                                 `IRQEPB_FLD_1, `IRQEPB_FLD_0};
   localparam int E_REG [NS-NP] = '{0, 0, 0, 1, 1, 1};
   localparam int E_BIT [NS-NP] = '{`IRQEPB_B_FAULT_A, `IRQEPB_B_CALCLK,
                                    `IRQEPB_B_PWM, `IRQEPB_B_CTU,
                                    `IRQEPB_B_SERR, `IRQEPB_B_FAULT_B};
   localparam logic [15:0] EN_MSK [2] = '{`IRQEPB_MSK_EN3, `IRQEPB_MSK_EN4};
   localparam logic [15:0] PR_MSK [3] = '{`IRQEPB_MSK_PRI0, `IRQEPB_MSK_PRI1,
                                          `IRQEPB_MSK_PRI2};
   localparam logic [15:0] PR_RST [3] = '{`IRQEPB_RST_PRI0, `IRQEPB_RST_PRI1,
                                          `IRQEPB_RST_PRI2};

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   irqepb_state_type          st_q;
   irqepb_sel_type            sel;
   logic [15:0]               en_q [2];
   logic [15:0]               pri_q [3];
   logic [NS-1:0]             flag_q;
   logic [NS-1:0]             flag_d;
   logic [NS-1:0]             flag_clr;
   logic [31:0]               prdata_q;
   logic                      err_q;
   logic                      wr;
   logic                      irq_req_q;
   irqepb_lvl_type            irq_level_q;
   logic [4:0]                irq_src_q;
   logic [15:0]               lane_msk;

   irqepb_arb_if #(.N(NS)) arb_if ();

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // address decode, shared by read capture and write strobe
   function automatic irqepb_sel_type reg_sel(input logic [ADDR_W-1:0] a);
      if (a[1:0] != 2'h0)
         return IRQEPB_SEL_NONE;
      else if (a == ADDR_W'(`IRQEPB_OFS_EN3))
         return IRQEPB_SEL_EN3;
      else if (a == ADDR_W'(`IRQEPB_OFS_EN4))
         return IRQEPB_SEL_EN4;
      else if (a == ADDR_W'(`IRQEPB_OFS_PRI0))
         return IRQEPB_SEL_PRI0;
      else if (a == ADDR_W'(`IRQEPB_OFS_PRI1))
         return IRQEPB_SEL_PRI1;
      else if (a == ADDR_W'(`IRQEPB_OFS_PRI2))
         return IRQEPB_SEL_PRI2;
      else if (a == ADDR_W'(`IRQEPB_OFS_FLAG))
         return IRQEPB_SEL_FLAG;
      else if (a == ADDR_W'(`IRQEPB_OFS_STAT))
         return IRQEPB_SEL_STAT;
      else
         return IRQEPB_SEL_NONE;
   endfunction : reg_sel

   // byte-lane merge, then drop unimplemented bits
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] lm,
                                         input logic [15:0] keep);
      return ((old & ~lm) | (pwdata[15:0] & lm)) & keep;
   endfunction : merge

   // three-bit field of a priority word
   function automatic irqepb_lvl_type fld(input logic [15:0] w, input int lsb);
      return w[lsb +: 3];
   endfunction : fld

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign sel      = reg_sel(paddr);
   assign lane_msk = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   // one wait state so read data leaves a flip-flop
   assign pready   = (st_q == IRQEPB_ACK) && ce;
   assign pslverr  = pready && err_q;
   assign prdata   = prdata_q;
   // writes land only at the completing edge, never on an error
   assign wr       = pready && psel && penable && pwrite && !err_q;

   // phase tracking
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= IRQEPB_IDLE;
      else if (ce)
      begin
         case (st_q)
            IRQEPB_IDLE: if (psel && penable) st_q <= IRQEPB_ACK;
            IRQEPB_ACK:  st_q <= IRQEPB_IDLE;
            default:     st_q <= IRQEPB_IDLE;
         endcase
      end
   end

   // read capture and error flag, taken on entry to the access phase
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_q <= 32'h0000_0000;
         err_q    <= 1'b0;
      end
      else if (ce && (st_q == IRQEPB_IDLE) && psel && penable)
      begin
         err_q    <= (sel == IRQEPB_SEL_NONE);
         prdata_q <= 32'h0000_0000;
         if (!pwrite)
         begin
            case (sel)
               IRQEPB_SEL_EN3:  prdata_q[15:0] <= en_q[0];
               IRQEPB_SEL_EN4:  prdata_q[15:0] <= en_q[1];
               IRQEPB_SEL_PRI0: prdata_q[15:0] <= pri_q[0];
               IRQEPB_SEL_PRI1: prdata_q[15:0] <= pri_q[1];
               IRQEPB_SEL_PRI2: prdata_q[15:0] <= pri_q[2];
               IRQEPB_SEL_FLAG: prdata_q[NS-1:0] <= flag_q;
               IRQEPB_SEL_STAT: prdata_q[8:0] <= {irq_req_q, irq_level_q, irq_src_q};
               default:         prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // enable words
   // ----------------------------------------------------------------
   // only masked bits are stored, so empty bits stay zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_q[0] <= `IRQEPB_RST_EN;
         en_q[1] <= `IRQEPB_RST_EN;
      end
      else if (ce && wr)
      begin
         if (sel == IRQEPB_SEL_EN3)
            en_q[0] <= merge(en_q[0], lane_msk, EN_MSK[0]);
         else if (sel == IRQEPB_SEL_EN4)
            en_q[1] <= merge(en_q[1], lane_msk, EN_MSK[1]);
      end
   end

   // ----------------------------------------------------------------
   // priority words
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int r = 0; r < 3; r++)
            pri_q[r] <= PR_RST[r];
      end
      else if (ce && wr)
      begin
         if (sel == IRQEPB_SEL_PRI0)
            pri_q[0] <= merge(pri_q[0], lane_msk, PR_MSK[0]);
         else if (sel == IRQEPB_SEL_PRI1)
            pri_q[1] <= merge(pri_q[1], lane_msk, PR_MSK[1]);
         else if (sel == IRQEPB_SEL_PRI2)
            pri_q[2] <= merge(pri_q[2], lane_msk, PR_MSK[2]);
      end
   end

   // ----------------------------------------------------------------
   // request flags
   // ----------------------------------------------------------------
   // write one clears; a pulse in the same cycle wins over the clear
   assign flag_clr = (wr && (sel == IRQEPB_SEL_FLAG))
                     ? (pwdata[NS-1:0] & {pstrb[2], lane_msk}) : '0;
   assign flag_d   = (flag_q & ~flag_clr) | src_pulse;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flag_q <= '0;
      else if (ce)
         flag_q <= flag_d;
   end

   // ----------------------------------------------------------------
   // eligibility per source
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NS; g++)
      begin : g_src
         if (g < NP)
         begin : g_pri
            // level from the local field, enable from outside
            assign arb_if.lvl[g]  = fld(pri_q[P_REG[g]], P_LSB[g]);
            assign arb_if.elig[g] = flag_q[g] && ext_en[g]
                                    && (arb_if.lvl[g] != 3'h0);
         end
         else
         begin : g_en
            // enable local, level from outside
            assign arb_if.lvl[g]  = ext_prio[3*(g-NP) +: 3];
            assign arb_if.elig[g] = flag_q[g] && en_q[E_REG[g-NP]][E_BIT[g-NP]]
                                    && (arb_if.lvl[g] != 3'h0);
         end
      end
   endgenerate

   irqepb_resolver #(.N(NS)) u_res
   (
      .arb (arb_if.arb)
   );

   // ----------------------------------------------------------------
   // request to the core
   // ----------------------------------------------------------------
   // registered so the core sees a clean level a cycle after the cause
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_req_q   <= 1'b0;
         irq_level_q <= 3'h0;
         irq_src_q   <= 5'h00;
      end
      else if (ce)
      begin
         irq_req_q   <= arb_if.win_valid;
         irq_level_q <= arb_if.win_lvl;
         irq_src_q   <= arb_if.win_idx;
      end
   end

   assign irq_req   = irq_req_q;
   assign irq_level = irq_level_q;
   assign irq_src   = irq_src_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [NS-1:0] elig_p;
   irqepb_lvl_type [NS-1:0] lvl_p;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         elig_p <= '0;
         lvl_p  <= '0;
      end
      else
      begin
         elig_p <= arb_if.elig;
         lvl_p  <= arb_if.lvl;
      end
   end

   AST_EN3_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr && (sel == IRQEPB_SEL_EN3) && (pstrb[1:0] == 2'h3)
      |=> en_q[0] == ($past(pwdata[15:0]) & 16'hc200))
      else $error("enable word 3 did not take the write");

   AST_EN4_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr && (sel == IRQEPB_SEL_EN4) && (pstrb[1:0] == 2'h3)
      |=> en_q[1] == ($past(pwdata[15:0]) & 16'h2003))
      else $error("enable word 4 did not take the write");

   AST_PRI1_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr && (sel == IRQEPB_SEL_PRI1) && (pstrb[1:0] == 2'h3)
      |=> pri_q[1] == ($past(pwdata[15:0]) & 16'h7770))
      else $error("priority word 1 did not take the write");

   AST_PRI_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> (pri_q[0] == 16'h4444) && (pri_q[2] == 16'h4444)
                       && (en_q[0] == 16'h0000))
      else $error("bank left reset with wrong values");

   AST_LEVEL_NONZERO: assert property (@(posedge clk) disable iff (!rst_n)
      irq_req_q |-> irq_level_q != 3'h0)
      else $error("request raised at level zero");

   AST_REQ_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
      $past(ce) && irq_req_q
      |-> elig_p[irq_src_q] && (lvl_p[irq_src_q] == irq_level_q))
      else $error("request without an eligible source at that level");

   AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
      ce && src_pulse[0] |=> flag_q[0])
      else $error("source pulse did not set its flag");

   AST_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
      psel && penable && !pready && ce && (st_q == IRQEPB_IDLE) && !pwrite
      && (sel == IRQEPB_SEL_PRI1) ##1 ce |-> pready && (prdata[31:15] == 17'h0)
      && (prdata[3:0] == 4'h0))
      else $error("read answer late or with empty bits set");

   CVR_WRITE_EN: cover property (@(posedge clk) disable iff (!rst_n)
      wr && (sel == IRQEPB_SEL_EN3));
   CVR_REQ_TOP: cover property (@(posedge clk) disable iff (!rst_n)
      irq_req_q && (irq_level_q == 3'h7));
   CVR_SET_CLR: cover property (@(posedge clk) disable iff (!rst_n)
      (|(flag_clr & src_pulse)));
endmodule : irqepb_bank
`default_nettype wire

// ### logic/irqepb_map.svh
// Purpose: register map, reset values and field positions of the bank
// Assumes: 32-bit apb data, registers in the low 16 bits of each word, the flag word in the low 17
// Notes:   definitions only, included by bare name
`ifndef IRQEPB_MAP_SVH
`define IRQEPB_MAP_SVH
// ----------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------
`define IRQEPB_OFS_EN3   12'h000
`define IRQEPB_OFS_EN4   12'h004
`define IRQEPB_OFS_PRI0  12'h008
`define IRQEPB_OFS_PRI1  12'h00c
`define IRQEPB_OFS_PRI2  12'h010
`define IRQEPB_OFS_FLAG  12'h014
`define IRQEPB_OFS_STAT  12'h018
// ----------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------
`define IRQEPB_RST_EN    16'h0000
`define IRQEPB_RST_PRI0  16'h4444
`define IRQEPB_RST_PRI1  16'h4440
`define IRQEPB_RST_PRI2  16'h4444
`define IRQEPB_MSK_EN3   16'hc200
`define IRQEPB_MSK_EN4   16'h2003
`define IRQEPB_MSK_PRI0  16'h7777
`define IRQEPB_MSK_PRI1  16'h7770
`define IRQEPB_MSK_PRI2  16'h7777
// ----------------------------------------------------------------
// enable bit positions
// ----------------------------------------------------------------
`define IRQEPB_B_FAULT_A 15
`define IRQEPB_B_CALCLK  14
`define IRQEPB_B_PWM     9
`define IRQEPB_B_CTU     13
`define IRQEPB_B_SERR    1
`define IRQEPB_B_FAULT_B 0
// ----------------------------------------------------------------
// priority field low bits (fields are three bits wide)
// ----------------------------------------------------------------
`define IRQEPB_FLD_3     12
`define IRQEPB_FLD_2     8
`define IRQEPB_FLD_1     4
`define IRQEPB_FLD_0     0
`define IRQEPB_NSRC      17
`define IRQEPB_NPRI      11
`endif

// ### logic/irqepb_pkg.sv
// Purpose: shared types of the enable and priority bank
// Assumes: nothing beyond the map header
// Notes:   constants live in irqepb_map.svh
`default_nettype none
package irqepb_pkg;
   // apb answer phase
   typedef enum logic [0:0]
   {
      IRQEPB_IDLE = 1'b0,
      IRQEPB_ACK  = 1'b1
   } irqepb_state_type;
   // register selected by an address
   typedef enum logic [2:0]
   {
      IRQEPB_SEL_EN3  = 3'b000,
      IRQEPB_SEL_EN4  = 3'b001,
      IRQEPB_SEL_PRI0 = 3'b010,
      IRQEPB_SEL_PRI1 = 3'b011,
      IRQEPB_SEL_PRI2 = 3'b100,
      IRQEPB_SEL_FLAG = 3'b101,
      IRQEPB_SEL_STAT = 3'b110,
      IRQEPB_SEL_NONE = 3'b111
   } irqepb_sel_type;
   typedef logic [2:0] irqepb_lvl_type;
endpackage : irqepb_pkg
`default_nettype wire

// ### logic/irqepb_arb_if.sv
// Purpose: carries candidate requests to the resolver and the winner back
// Assumes: one clock, resolver is purely combinational
// Notes:   lowest source index wins a tie
`timescale 1ns/1ps
`default_nettype none
interface irqepb_arb_if
   import irqepb_pkg::*;
#(
   parameter int N = 17
);
   logic [N-1:0]              elig;
   irqepb_lvl_type [N-1:0]    lvl;
   logic                      win_valid;
   irqepb_lvl_type            win_lvl;
   logic [4:0]                win_idx;
   modport bank (output elig, output lvl, input win_valid, input win_lvl, input win_idx);
   modport arb  (input elig, input lvl, output win_valid, output win_lvl, output win_idx);
endinterface : irqepb_arb_if
`default_nettype wire

// ### logic/irqepb_resolver.sv
// Purpose: picks the eligible source with the highest level
// Assumes: level 0 sources are never marked eligible
// Notes:   combinational; the bank registers the result
`timescale 1ns/1ps
`default_nettype none
module irqepb_resolver
   import irqepb_pkg::*;
#(
   parameter int N = 17
)
(
   irqepb_arb_if.arb  arb
);
   // ----------------------------------------------------------------
   // linear scan
   // ----------------------------------------------------------------
   // strict compare keeps the lower index on equal levels
   always_comb
   begin
      arb.win_valid = 1'b0;
      arb.win_lvl   = 3'h0;
      arb.win_idx   = 5'h00;
      for (int i = 0; i < N; i++)
      begin
         if (arb.elig[i] && (arb.lvl[i] > arb.win_lvl))
         begin
            arb.win_valid = 1'b1;
            arb.win_lvl   = arb.lvl[i];
            arb.win_idx   = 5'(i);
         end
      end
   end
endmodule : irqepb_resolver
`default_nettype wire

// ### verification/irqepb_src_model.sv
// Purpose: peripheral side, turns event levels into one-cycle request pulses
// Assumes: fire changes just after a rising edge of clk
// Notes:   a held event fires once, like a peripheral flagging one occurrence
`timescale 1ns/1ps
`default_nettype none
module irqepb_src_model
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [16:0] fire,
   output logic [16:0]      src_pulse
);
   logic [16:0] fire_q;

   // last level seen, so a long event cannot re-trigger
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fire_q <= 17'h00000;
      end
      else
      begin
         fire_q <= fire;
      end
   end

   // pulse only on the rising side of an event
   assign src_pulse = fire & ~fire_q;
endmodule : irqepb_src_model
`default_nettype wire

// ### verification/irq_enable_priority_bank_tb.sv
// Purpose: self-checking bench of the enable and priority bank
// Assumes: ce held high, all byte lanes written
// Notes:   request pulses come from the peripheral model
`timescale 1ns/1ps
`default_nettype none
`include "irqepb_map.svh"
module irq_enable_priority_bank_tb;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err, irq_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [16:0] fire, src_pulse;
   logic [10:0] ext_en;
   logic [17:0] ext_prio;
   logic [2:0]  irq_level;
   logic [4:0]  irq_src;
   int          fails, num_checks, k;
   logic [11:0] ofs[5]  = '{`IRQEPB_OFS_EN3, `IRQEPB_OFS_EN4, `IRQEPB_OFS_PRI0,
                            `IRQEPB_OFS_PRI1, `IRQEPB_OFS_PRI2};
   logic [15:0] rstv[5] = '{`IRQEPB_RST_EN, `IRQEPB_RST_EN, `IRQEPB_RST_PRI0,
                            `IRQEPB_RST_PRI1, `IRQEPB_RST_PRI2};
   logic [15:0] msk[5]  = '{16'hc200, 16'h2003, 16'h7777, 16'h7770, 16'h7777};
   int          bitp[6] = '{15, 14, 9, 13, 1, 0};

   irqepb_bank u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_pulse(src_pulse), .ext_en(ext_en), .ext_prio(ext_prio),
      .irq_req(irq_req), .irq_level(irq_level), .irq_src(irq_src));
   irqepb_src_model u_src (.clk(clk), .rst_n(rst_n), .fire(fire),
      .src_pulse(src_pulse));

   // ---------------------------------------------------------------
   // clock and helpers
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task wrap_up;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   task chk_word(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch at %0t: word %h exp %h", $time, g, e);
      end
   endtask : chk_word

   task chk_irq(input logic [8:0] e);
      num_checks++;
      if ({irq_req, irq_level, irq_src} !== e)
      begin
         fails++;
         $display("mismatch at %0t: request %h exp %h", $time,
                  {irq_req, irq_level, irq_src}, e);
      end
   endtask : chk_irq

   // one apb transfer; an idle cycle first keeps drivers single per step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
      begin
         fails++;
         $display("mismatch at %0t: no answer on the bus", $time);
         wrap_up();
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // event on source i, then let flag and output register settle
   task event_wait(input int i);
      @(posedge clk);
      fire[i] <= 1'b1;
      @(posedge clk);
      fire[i] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : event_wait

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, fire} = '0;
      ext_en = 11'h000;
      ext_prio = {6{3'b100}};
      fails = 0;
      num_checks = 0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, then all-ones writes read back masked
      for (k = 0; k < 5; k++)
      begin
         apb(1'b0, ofs[k], 32'h0);
         chk_word(rd, {16'h0, rstv[k]});
         apb(1'b1, ofs[k], 32'hffff_ffff);
         apb(1'b0, ofs[k], 32'h0);
         chk_word(rd, {16'h0, msk[k]});
         apb(1'b1, ofs[k], {16'h0, rstv[k]});
      end
      apb(1'b0, 12'h020, 32'h0);
      chk_word({31'h0, err}, 32'h1);
      chk_word(rd, 32'h0);
      // a misaligned word address is refused like an unmapped one
      apb(1'b0, 12'h009, 32'h0);
      chk_word({31'h0, err}, 32'h1);
      // a blocked request leaves the flag set but no request out
      event_wait(11);
      chk_irq(9'h000);
      apb(1'b0, `IRQEPB_OFS_FLAG, 32'h0);
      chk_word(rd, 32'h0000_0800);
      apb(1'b1, `IRQEPB_OFS_FLAG, 32'h0000_0800);
      apb(1'b0, `IRQEPB_OFS_FLAG, 32'h0);
      chk_word(rd, 32'h0);
      // each enable bit lets its own source through at its level
      for (k = 0; k < 6; k++)
      begin
         apb(1'b1, k < 3 ? ofs[0] : ofs[1], 32'h1 << bitp[k]);
         event_wait(11 + k);
         chk_irq({1'b1, 3'd4, 5'(11 + k)});
         apb(1'b1, k < 3 ? ofs[0] : ofs[1], 32'h0);
         repeat (2) @(posedge clk);
         chk_irq(9'h000);
         apb(1'b1, `IRQEPB_OFS_FLAG, 32'h1 << (11 + k));
      end
      // a zero level silences an enabled source, other levels pass
      ext_en <= 11'h001;
      apb(1'b1, `IRQEPB_OFS_PRI0, 32'h0000_0444);
      event_wait(0);
      chk_irq(9'h000);
      apb(1'b1, `IRQEPB_OFS_PRI0, 32'h0000_7444);
      repeat (2) @(posedge clk);
      chk_irq({1'b1, 3'd7, 5'd0});
      // status word mirrors the forwarded request, level and source
      apb(1'b0, `IRQEPB_OFS_STAT, 32'h0);
      chk_word(rd, 32'h0000_01e0);
      apb(1'b1, `IRQEPB_OFS_PRI0, 32'h0000_1444);
      repeat (2) @(posedge clk);
      chk_irq({1'b1, 3'd1, 5'd0});
      // higher level wins, equal levels go to the lower index
      ext_en <= 11'h003;
      event_wait(1);
      chk_irq({1'b1, 3'd4, 5'd1});
      apb(1'b1, `IRQEPB_OFS_PRI0, 32'h0000_1144);
      repeat (2) @(posedge clk);
      chk_irq({1'b1, 3'd1, 5'd0});
      wrap_up();
   end
endmodule : irq_enable_priority_bank_tb
`default_nettype wire
